//--- verilog/aio_defines.vh
// shared constants for the analog value coding block
`ifndef AIO_DEFINES_VH
`define AIO_DEFINES_VH
// register offsets
`define AIO_OFF_OCFG0 8'h00
`define AIO_OFF_OCFG1 8'h01
`define AIO_OFF_OCFG2 8'h02
`define AIO_OFF_OCFG3 8'h03
`define AIO_OFF_OUT0 8'h04
`define AIO_OFF_OUT1 8'h05
`define AIO_OFF_OUT2 8'h06
`define AIO_OFF_OUT3 8'h07
`define AIO_OFF_IMODE 8'h08
`define AIO_OFF_STATUS 8'h09
`define AIO_OFF_MASK 8'h0A
`define AIO_OFF_DIN 8'h0B
`define AIO_OFF_ERRNUM 8'h0C
`define AIO_OFF_MODEACT 8'h0D
`define AIO_OFF_IN_BASE 8'h10
// output mode codes
`define AIO_OMODE_V10 8'h00
`define AIO_OMODE_I020 8'h02
`define AIO_OMODE_I420 8'h03
// input mode codes, 3 bits per channel
`define AIO_IMODE_OFF 3'h0
`define AIO_IMODE_RTD400 3'h1
`define AIO_IMODE_RTD70 3'h2
`define AIO_IMODE_RTD400_3W 3'h3
`define AIO_IMODE_RTD70_3W 3'h4
`define AIO_IMODE_DIN 3'h5
// numeric codes
`define AIO_VAL_OVF 16'h7FFF
`define AIO_VAL_UNF 16'h8001
`define AIO_VAL_LO 16'hFC02
`define AIO_VAL_HI400 16'h1FFE
`define AIO_VAL_HI70 16'h0599
`define AIO_FS_POS 16'h7FF8
`define AIO_FS_NEG 16'h8008
`define AIO_ERR_CLASS 4'h4
`define AIO_ERR_OPEN_SHORT 8'h09
// drop product at the bottom of both ranges, calibration point with a plain default
`define AIO_RTD_BASE 16'h0400
// width of each temperature range in codes
`define AIO_RTD_SPAN400 32'h000023FC
`define AIO_RTD_SPAN70 32'h00000997
// digital input filter time
`define AIO_DIN_FILT_NS 7000000
`define AIO_CLK_NS 5
`endif

//--- verilog/aio_lin_rom.v
// sensor linearization table, registered read
`timescale 1ns/1ps
module aio_lin_rom
#(
  parameter AW = 6
)
(
  input wire sys_clk,
  input wire [AW-1:0] addr,
  output reg [15:0] data
);
  // piecewise breakpoints: counts per segment slightly reduced toward top (curve bends down)
  always @(posedge sys_clk)
  begin
    data <= 16'h0040 - {10'h000, addr[AW-1:AW-6] >> 3};
  end
endmodule // aio_lin_rom

//--- verilog/aio_value_coding.v
// analog value coding for sensor inputs and converter outputs
//
// Summary of operation
// - rtd maps range linearly to fixed codes
// - sensor curve linearized inside the block
// - over range +32767, under range -32767
// - open sensor +32767, shorted sensor -32767
// - fault lights overload, logs class four error nine
// - one current sink multiplexed over eight channels
// - 3-wire result stored in odd word
// - digital input high above about seven volts
// - digital input filter fixed at 7 ms
// - output mode from low config byte
// - high config byte ignored
// - new output mode applies at next start
// - converter takes 12 of 16 bits
// - voltage mode proportional, signed
// - current modes unsigned, 4 mA offset option
`timescale 1ns/1ps
`include "aio_defines.vh"
module aio_value_coding
#(
  parameter NCH = 8,
  parameter RES_W = 16,
  parameter FILT_CYC = `AIO_DIN_FILT_NS / `AIO_CLK_NS
)
(
  input wire sys_clk,
  input wire srst,
  input wire warm_start,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [RES_W-1:0] adc_drop,
  input wire adc_valid,
  input wire adc_open,
  input wire adc_short,
  input wire [NCH-1:0] din_above_7v,
  output reg [2:0] sink_sel,
  output reg adc_start,
  output reg ovl_led,
  output reg err_log,
  output reg [3:0] err_class,
  output reg [7:0] err_num,
  output reg [47:0] dac_code,
  output reg [3:0] dac_cur_mode,
  output reg [3:0] dac_offset_4ma,
  output wire irq
);
  localparam [31:0] FILT_W = FILT_CYC;
  localparam [23:0] FILT = FILT_W[23:0];
  // state machine, one-hot
  localparam [3:0] ST_START = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_LIN = 4'b0100;
  localparam [3:0] ST_STORE = 4'b1000;
  reg [15:0] ocfg_reg [0:3];
  reg [1:0] omode_reg [0:3];
  reg [15:0] out_reg [0:3];
  reg [23:0] imode_reg;
  reg [15:0] in_reg [0:NCH-1];
  reg [1:0] status_reg;
  reg [1:0] mask_reg;
  reg [NCH-1:0] fault_reg;
  reg [3:0] state_reg;
  reg [15:0] first_drop_reg;
  reg [15:0] raw_reg;
  reg [15:0] res_reg;
  reg [1:0] res_kind_reg;
  reg [NCH-1:0] din_s1_reg;
  reg [NCH-1:0] din_s2_reg;
  reg [NCH-1:0] din_reg;
  reg [23:0] filt_cnt_reg [0:NCH-1];
  reg open_s1_reg;
  reg open_s2_reg;
  reg short_s1_reg;
  reg short_s2_reg;
  reg valid_s1_reg;
  reg valid_s2_reg;
  reg [15:0] drop_s1_reg;
  reg [15:0] drop_s2_reg;
  wire [15:0] lin_slope;
  integer i;

  // mode of one input channel
  function [2:0] imode_of;
    input [23:0] m;
    input [2:0] ch;
    begin
      imode_of = m[ch*3 +: 3];
    end
  endfunction

  // output word to 12-bit converter code
  function [11:0] dac_conv;
    input [15:0] v;
    input [1:0] mode;
    reg [15:0] c;
    begin
      c = v;
      if (mode == `AIO_OMODE_V10)
      begin
        if ($signed(v) > $signed(`AIO_FS_POS)) c = `AIO_FS_POS;
        if ($signed(v) < $signed(`AIO_FS_NEG)) c = `AIO_FS_NEG;
        dac_conv = c[15:4] + 12'h800;
      end
      else
      begin
        if (v[15]) c = 16'h0000;
        else if (v > `AIO_FS_POS) c = `AIO_FS_POS;
        dac_conv = c[14:3];
      end
    end
  endfunction

  assign irq = |(status_reg & mask_reg);

  // pin synchronisers
  always @(posedge sys_clk)
  begin
    din_s1_reg <= din_above_7v;
    din_s2_reg <= din_s1_reg;
    open_s1_reg <= adc_open;
    open_s2_reg <= open_s1_reg;
    short_s1_reg <= adc_short;
    short_s2_reg <= short_s1_reg;
    valid_s1_reg <= adc_valid;
    valid_s2_reg <= valid_s1_reg;
    drop_s1_reg <= adc_drop;
    drop_s2_reg <= drop_s1_reg;
  end

  // digital input filter per channel
  always @(posedge sys_clk)
  begin
    for (i = 0; i < NCH; i = i + 1)
    begin
      if (srst)
      begin
        din_reg[i] <= 1'b0;
        filt_cnt_reg[i] <= 24'h000000;
      end
      else if (din_s2_reg[i] == din_reg[i])
        filt_cnt_reg[i] <= 24'h000000;
      else if (filt_cnt_reg[i] >= FILT - 24'h000001)
      begin
        din_reg[i] <= din_s2_reg[i];
        filt_cnt_reg[i] <= 24'h000000;
      end
      else
        filt_cnt_reg[i] <= filt_cnt_reg[i] + 24'h000001;
    end
  end

  aio_lin_rom #(.AW(6)) u_rom
  (
    .sys_clk(sys_clk),
    .addr(raw_reg[12:7]),
    .data(lin_slope)
  );

  // sink multiplex and conversion sequencer
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_reg <= ST_START;
      sink_sel <= 3'h0;
      adc_start <= 1'b0;
      raw_reg <= 16'h0000;
      res_reg <= 16'h0000;
      res_kind_reg <= 2'h0;
      first_drop_reg <= 16'h0000;
      fault_reg <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
        in_reg[i] <= 16'h0000;
    end
    else
    begin
      adc_start <= 1'b0;
      case (state_reg)
        ST_START:
        begin
          adc_start <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (valid_s2_reg)
          begin
            raw_reg <= drop_s2_reg;
            res_kind_reg <= open_s2_reg ? 2'h1 : (short_s2_reg ? 2'h2 : 2'h0);
            state_reg <= ST_LIN;
          end
        end
        ST_LIN:
        begin
          // odd drop minus twice the even drop removes lead resistance in 3-wire pairs
          if (sink_sel[0] && (imode_of(imode_reg, sink_sel) == `AIO_IMODE_RTD400_3W ||
              imode_of(imode_reg, sink_sel) == `AIO_IMODE_RTD70_3W))
            res_reg <= raw_reg - first_drop_reg - first_drop_reg;
          else
            res_reg <= raw_reg;
          state_reg <= ST_STORE;
        end
        ST_STORE:
        begin
          first_drop_reg <= raw_reg;
          fault_reg[sink_sel] <= (res_kind_reg != 2'h0) && imode_of(imode_reg, sink_sel) >= `AIO_IMODE_RTD400 &&
            imode_of(imode_reg, sink_sel) <= `AIO_IMODE_RTD70_3W;
          case (imode_of(imode_reg, sink_sel))
            `AIO_IMODE_RTD400, `AIO_IMODE_RTD70, `AIO_IMODE_RTD400_3W, `AIO_IMODE_RTD70_3W:
            begin
              if (imode_of(imode_reg, sink_sel) >= `AIO_IMODE_RTD400_3W && !sink_sel[0])
                in_reg[sink_sel] <= in_reg[sink_sel]; // even half only feeds odd word
              else if (res_kind_reg == 2'h1)
                in_reg[sink_sel] <= `AIO_VAL_OVF;
              else if (res_kind_reg == 2'h2)
                in_reg[sink_sel] <= `AIO_VAL_UNF;
              else
                in_reg[sink_sel] <= rtd_code(res_reg, lin_slope,
                  imode_of(imode_reg, sink_sel) == `AIO_IMODE_RTD70 ||
                  imode_of(imode_reg, sink_sel) == `AIO_IMODE_RTD70_3W);
            end
            `AIO_IMODE_DIN: in_reg[sink_sel] <= {15'h0000, din_reg[sink_sel]};
            default: in_reg[sink_sel] <= 16'h0000;
          endcase
          sink_sel <= sink_sel + 3'h1;
          state_reg <= ST_START;
        end
        default: state_reg <= ST_START;
      endcase
    end
  end

  // resistance drop to temperature code
  function [15:0] rtd_code;
    input [15:0] drop;
    input [15:0] slope;
    input narrow;
    reg [31:0] t;
    begin
      t = ({16'h0000, drop} * {16'h0000, slope}) >> 6;
      if (t < {16'h0000, `AIO_RTD_BASE})
        rtd_code = `AIO_VAL_UNF;
      else if (t - {16'h0000, `AIO_RTD_BASE} > (narrow ? `AIO_RTD_SPAN70 : `AIO_RTD_SPAN400))
        rtd_code = `AIO_VAL_OVF;
      else
        rtd_code = t[15:0] - `AIO_RTD_BASE + `AIO_VAL_LO;
    end
  endfunction

  // fault indication and error log
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      ovl_led <= 1'b0;
      err_log <= 1'b0;
      err_class <= 4'h0;
      err_num <= 8'h00;
    end
    else
    begin
      ovl_led <= |fault_reg;
      err_log <= (|fault_reg) && !ovl_led;
      if ((|fault_reg) && !ovl_led)
      begin
        err_class <= `AIO_ERR_CLASS;
        err_num <= `AIO_ERR_OPEN_SHORT;
      end
    end
  end

  // register writes, output modes latched at start
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      imode_reg <= 24'h000000;
      mask_reg <= 2'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
        ocfg_reg[i] <= 16'h0000;
        omode_reg[i] <= 2'h0;
        out_reg[i] <= 16'h0000;
      end
    end
    else
    begin
      if (warm_start)
        for (i = 0; i < 4; i = i + 1)
          omode_reg[i] <= ocfg_reg[i][1:0];
      if (reg_wr)
      begin
        if (reg_addr <= `AIO_OFF_OCFG3)
          ocfg_reg[reg_addr[1:0]] <= reg_wdata;
        else if (reg_addr <= `AIO_OFF_OUT3)
          out_reg[reg_addr[1:0]] <= reg_wdata;
        else if (reg_addr == `AIO_OFF_IMODE)
          imode_reg[15:0] <= reg_wdata;
        else if (reg_addr == `AIO_OFF_MODEACT)
          imode_reg[23:16] <= reg_wdata[7:0];
        else if (reg_addr == `AIO_OFF_MASK)
          mask_reg <= reg_wdata[1:0];
      end
    end
  end

  // sticky status: bit0 fault, bit1 new error; set wins over read clear
  always @(posedge sys_clk)
  begin
    if (srst)
      status_reg <= 2'h0;
    else
      status_reg <= ((reg_rd && reg_addr == `AIO_OFF_STATUS) ? 2'h0 : status_reg) |
                    {err_log, |fault_reg & !ovl_led};
  end

  // register reads
  always @(posedge sys_clk)
  begin
    if (srst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      if (reg_addr <= `AIO_OFF_OCFG3)
        reg_rdata <= ocfg_reg[reg_addr[1:0]];
      else if (reg_addr <= `AIO_OFF_OUT3)
        reg_rdata <= out_reg[reg_addr[1:0]];
      else if (reg_addr == `AIO_OFF_IMODE)
        reg_rdata <= imode_reg[15:0];
      else if (reg_addr == `AIO_OFF_STATUS)
        reg_rdata <= {14'h0000, status_reg};
      else if (reg_addr == `AIO_OFF_MASK)
        reg_rdata <= {14'h0000, mask_reg};
      else if (reg_addr == `AIO_OFF_DIN)
        reg_rdata <= {{(16-NCH){1'b0}}, din_reg};
      else if (reg_addr == `AIO_OFF_ERRNUM)
        reg_rdata <= {4'h0, err_class, err_num};
      else if (reg_addr == `AIO_OFF_MODEACT)
        reg_rdata <= {omode_reg[3], omode_reg[2], omode_reg[1], omode_reg[0], imode_reg[23:16]};
      else if (reg_addr >= `AIO_OFF_IN_BASE && reg_addr < `AIO_OFF_IN_BASE + NCH)
        reg_rdata <= in_reg[reg_addr[2:0]];
      else
        reg_rdata <= 16'h0000;
    end
  end

  // converter codes per output channel
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      dac_code <= 48'h000000000000;
      dac_cur_mode <= 4'h0;
      dac_offset_4ma <= 4'h0;
    end
    else
      for (i = 0; i < 4; i = i + 1)
      begin
        dac_code[i*12 +: 12] <= dac_conv(out_reg[i], omode_reg[i]);
        dac_cur_mode[i] <= omode_reg[i][1];
        dac_offset_4ma[i] <= (omode_reg[i] == `AIO_OMODE_I420);
      end
  end
endmodule // aio_value_coding

//--- tb/aio_chk.sv
// port checker for the value coding block
`timescale 1ns/1ps
module aio_chk (
  input wire sys_clk,
  input wire srst,
  input wire warm_start,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire adc_start,
  input wire ovl_led,
  input wire err_log,
  input wire [3:0] err_class,
  input wire [7:0] err_num,
  input wire [3:0] dac_cur_mode,
  input wire [3:0] dac_offset_4ma,
  input wire irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // steps of a fault report
  sequence s_led;
    ##[0:2] ovl_led;
  endsequence
  sequence s_pulse;
    err_log ##1 !err_log;
  endsequence
  chk_reset_clean: assert property ($fell(srst) |-> dac_cur_mode == 4'h0 && !irq && !err_log)
    else $error("outputs not clear after reset");
  chk_mode_hold: assert property (!$stable(dac_cur_mode) |-> $past(warm_start) || $past(warm_start, 2) || $past(srst))
    else $error("output mode changed without a start");
  chk_offset_cur: assert property ((dac_offset_4ma & ~dac_cur_mode) == 4'h0)
    else $error("offset set outside current mode");
  chk_err_codes: assert property (err_log |-> err_class == 4'h4 && err_num == 8'h09)
    else $error("wrong error class or number");
  chk_err_led: assert property (err_log |-> s_led)
    else $error("error logged without overload lamp");
  chk_err_pulse: assert property (err_log |-> s_pulse)
    else $error("error log longer than one cycle");
  chk_adc_pulse: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  chk_rd_unmapped: assert property (reg_rd && reg_addr == 8'hFF |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule // aio_chk
bind aio_value_coding aio_chk i_chk (.sys_clk(sys_clk), .srst(srst), .warm_start(warm_start),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_start(adc_start),
  .ovl_led(ovl_led), .err_log(err_log), .err_class(err_class), .err_num(err_num),
  .dac_cur_mode(dac_cur_mode), .dac_offset_4ma(dac_offset_4ma), .irq(irq));

//--- tb/aio_sensor_model.sv
// sensor front end model answering each conversion
`timescale 1ns/1ps
module aio_sensor_model (
  input wire sys_clk,
  input wire [2:0] sink_sel,
  input wire adc_start,
  input wire [1:0] fault,
  input wire [15:0] level,
  input wire three_wire,
  output reg [15:0] adc_drop,
  output reg adc_valid,
  output wire adc_open,
  output wire adc_short
);
  // drop of one lead; odd channel sees sensor plus both leads in 3-wire wiring
  localparam [15:0] WIRE_DROP = 16'h1800;
  reg [1:0] cnt_reg = 2'h0;
  initial adc_drop = 16'h0000;
  initial adc_valid = 1'b0;
  // open and short detector levels
  assign adc_open = fault[0];
  assign adc_short = fault[1];
  // answer the selected channel three cycles after start
  always @(posedge sys_clk)
  begin
    adc_valid <= cnt_reg == 2'h1;
    cnt_reg <= (adc_start === 1'b1) ? 2'h3 : (cnt_reg != 2'h0 ? cnt_reg - 2'h1 : 2'h0);
    if (cnt_reg != 2'h1)
      adc_drop <= ~adc_drop;
    else if (!three_wire)
      adc_drop <= level;
    else if (sink_sel[0])
      adc_drop <= level + WIRE_DROP + WIRE_DROP;
    else
      adc_drop <= WIRE_DROP;
  end
endmodule // aio_sensor_model

//--- tb/aio_value_coding_tb_top.sv
// self-checking bench for the value coding block
`timescale 1ns/1ps
module aio_value_coding_tb_top;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg warm_start = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] din = 8'h00;
  reg [1:0] fault = 2'h0;
  reg [15:0] lvl = 16'h0800;
  reg three_wire = 1'b0;
  wire [15:0] reg_rdata, adc_drop;
  wire [2:0] sink_sel;
  wire adc_start, adc_valid, adc_open, adc_short, ovl_led, err_log, irq;
  wire [3:0] err_class, cur, ofs;
  wire [7:0] err_num;
  wire [47:0] dac;
  integer err_total = 0;
  integer n_checks = 0;
  integer i;
  reg [15:0] q;
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  aio_value_coding #(.FILT_CYC(20)) i_dut (.sys_clk(sys_clk), .srst(srst), .warm_start(warm_start),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_drop(adc_drop), .adc_valid(adc_valid), .adc_open(adc_open), .adc_short(adc_short),
    .din_above_7v(din), .sink_sel(sink_sel), .adc_start(adc_start), .ovl_led(ovl_led),
    .err_log(err_log), .err_class(err_class), .err_num(err_num), .dac_code(dac),
    .dac_cur_mode(cur), .dac_offset_4ma(ofs), .irq(irq));
  aio_sensor_model i_sens (.sys_clk(sys_clk), .sink_sel(sink_sel), .adc_start(adc_start),
    .fault(fault), .level(lvl), .three_wire(three_wire), .adc_drop(adc_drop), .adc_valid(adc_valid),
    .adc_open(adc_open), .adc_short(adc_short));
  // compare and count
  task chk(input [47:0] seen, input [47:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one-cycle register write
  task wr(input [7:0] a, input [15:0] d);
  begin
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask
  // one-cycle read, data in the following cycle
  task rd(input [7:0] a, output [15:0] d);
  begin
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  end
  endtask
  // bounded wait for an input word value
  task poll(input [7:0] a, input [15:0] e);
  begin
    q = ~e;
    for (i = 0; i < 2000 && q !== e; i = i + 1)
      rd(a, q);
    chk(q, e);
    if (q !== e)
      end_of_test;
  end
  endtask
  // temperature code inside the wide range, no error code
  function inr(input [15:0] v);
    inr = $signed(v) >= $signed(16'hFC02) && $signed(v) <= $signed(16'h1FFE);
  endfunction
  // bounded wait for an in-range temperature code
  task pollr(input [7:0] a);
  begin
    q = 16'h7FFF;
    for (i = 0; i < 2000 && !inr(q); i = i + 1)
      rd(a, q);
    chk(inr(q), 1'b1);
    if (!inr(q))
      end_of_test;
  end
  endtask
  // output value then converter code
  task dval(input [1:0] ch, input [15:0] v, input [11:0] e);
  begin
    wr(8'h04 + ch, v);
    cyc(4);
    chk(dac[ch*12 +: 12], e);
  end
  endtask
  task t_mode;
  begin
    wr(8'h00, 16'h0002);
    wr(8'h01, 16'h0003);
    wr(8'h02, 16'hFF00);
    rd(8'h01, q);
    chk(q, 16'h0003);
    dval(2'd0, 16'h0008, 12'h800);
    chk(cur, 4'h0);
    @(posedge sys_clk) warm_start <= 1'b1;
    @(posedge sys_clk) warm_start <= 1'b0;
    cyc(3);
    chk(cur, 4'h3);
    chk(ofs, 4'h2);
    dval(2'd0, 16'h7FF8, 12'hFFF);
    dval(2'd0, 16'h7FFF, 12'hFFF);
    dval(2'd0, 16'h0008, 12'h001);
    dval(2'd0, 16'h0007, 12'h000);
    dval(2'd1, 16'h0000, 12'h000);
    dval(2'd2, 16'h7FF8, 12'hFFF);
    dval(2'd2, 16'h0007, 12'h800);
    dval(2'd2, 16'h8008, 12'h000);
    dval(2'd2, 16'h8001, 12'h000);
  end
  endtask
  task t_din;
  begin
    wr(8'h08, 16'h0005);
    @(posedge sys_clk) din <= 8'h01;
    cyc(8);
    rd(8'h0B, q);
    chk(q[0], 1'b0);
    cyc(40);
    rd(8'h0B, q);
    chk(q[0], 1'b1);
  end
  endtask
  // range selection, linear span and range error codes
  task t_range;
  begin
    wr(8'h08, 16'h0002);
    lvl <= 16'h1000;
    poll(8'h10, 16'h7FFF);
    wr(8'h08, 16'h0001);
    pollr(8'h10);
    lvl <= 16'h7000;
    poll(8'h10, 16'h7FFF);
    lvl <= 16'h0100;
    poll(8'h10, 16'h8001);
  end
  endtask
  // 3-wire pair: leads alone would push the odd word over range
  task t_pair;
  begin
    lvl <= 16'h0800;
    three_wire <= 1'b1;
    wr(8'h08, 16'h001B);
    cyc(200);
    pollr(8'h11);
  end
  endtask
  task t_fault;
  begin
    three_wire <= 1'b0;
    wr(8'h0A, 16'h0000);
    wr(8'h08, 16'h0001);
    @(posedge sys_clk) fault <= 2'h1;
    poll(8'h10, 16'h7FFF);
    chk(ovl_led, 1'b1);
    rd(8'h0C, q);
    chk(q, 16'h0409);
    chk(irq, 1'b0);
    wr(8'h0A, 16'h0003);
    cyc(2);
    chk(irq, 1'b1);
    @(posedge sys_clk) fault <= 2'h2;
    poll(8'h10, 16'h8001);
    chk(ovl_led, 1'b1);
    @(posedge sys_clk) fault <= 2'h0;
    pollr(8'h10);
    chk(ovl_led, 1'b0);
    rd(8'h09, q);
    chk(q, 16'h0003);
    rd(8'h09, q);
    chk(q, 16'h0000);
    cyc(2);
    chk(irq, 1'b0);
    wr(8'hFF, 16'h1234);
    rd(8'hFF, q);
    chk(q, 16'h0000);
  end
  endtask
  // main sequence
  initial
  begin
    cyc(3);
    srst <= 1'b0;
    t_mode;
    t_din;
    t_range;
    t_pair;
    t_fault;
    end_of_test;
  end
endmodule // aio_value_coding_tb_top
